// ===== core/ccs_core.sv
// Control state, stack, register file and address decode of the core
module ccs_core
    import ccs_pkg::*;
(
    input  wire logic            clk_i,
    input  wire logic            rst_n_i,
    input  wire ccs_apb_req_type apb_i,
    output logic [31:0]          prdata_o,
    output logic                 pready_o,
    output logic                 pslverr_o,
    input  wire ccs_cmd_type     cmd_i,
    input  wire logic            mask_ok_i,
    input  wire logic            nmi_i,
    input  wire logic [7:0]      prog_rdata_i,
    output logic                 busy_o,
    output logic                 int_take_o,
    output logic                 prog_rd_o,
    output logic [15:0]          prog_addr_o,
    output logic [15:0]          pc_o,
    output logic [15:0]          sp_o,
    output logic [7:0]           psw_o,
    output logic [7:0]           alu_result_o,
    output logic                 stack_fault_o
);
    typedef enum logic [2:0] {ST_VLO, ST_VHI, ST_VDONE, ST_IDLE, ST_PUSH,
                              ST_POP} ccs_state_type;

    ccs_state_type  state_reg;
    ccs_op_type     op_reg;
    logic [1:0]     cnt_reg;
    logic [15:0]    vec_reg;
    logic [7:0]     vlo_reg;
    logic [15:0]    pc_reg;
    logic [15:0]    sp_reg;
    logic [7:0]     psw_reg;
    logic [7:0]     alu_reg;
    logic [7:0]     gr_reg [8];
    logic [7:0]     ram_reg [256];
    logic [7:0]     ram_idx_reg;
    logic [15:0]    probe_reg;
    logic           fault_reg;
    logic           take_reg;
    logic           pready_reg;
    logic           perr_reg;
    logic [31:0]    prdata_reg;

    // ************************************************************
    // Address decode
    // ************************************************************
    function automatic ccs_region_type region_of(input logic [15:0] a);
        ccs_region_type r;
        r = RG_PROGRAM;
        if (a >= SFR_FIRST)
            r = RG_SFR;
        // data area, backed by the RAM
        else if (a >= DATA_FIRST)
            r = RG_DATA;
        else if (a <= VEC_LAST)
            r = RG_VECTOR;
        else if (a >= TABLE_CALL_INSTRUCTION_FIRST && a <= TABLE_CALL_INSTRUCTION_LAST)
            r = RG_TABLE_CALL_INSTRUCTION;
        return r;
    endfunction

    function automatic logic [15:0] vector_of(input logic [3:0] src);
        case (src)
            4'h0:    return VEC_WATCHDOG;
            4'h1:    return VEC_EXT0;
            4'h2:    return VEC_EXT1;
            4'h3:    return VEC_EXT2;
            4'h4:    return VEC_SER_RX;
            4'h5:    return VEC_SER_TX;
            4'h6:    return VEC_TMR8;
            4'h7:    return VEC_TMR16;
            4'h8:    return VEC_CONV;
            default: return VEC_FIRST;
        endcase
    endfunction

    // ************************************************************
    // APB decode
    // ************************************************************
    logic        acc;
    logic        mapped;
    logic        wr;
    logic [11:0] ofs;
    logic [2:0]  bidx;
    logic [1:0]  pidx;

    assign ofs    = apb_i.paddr;
    assign bidx   = ofs[4:2];
    assign pidx   = ofs[3:2];
    assign acc    = apb_i.psel & apb_i.penable;
    assign mapped = (ofs[1:0] == 2'b00) && (ofs <= OFS_PROBE);
    assign wr     = acc & pready_reg & apb_i.pwrite & mapped;

    // ************************************************************
    // Stack addressing and ALU
    // ************************************************************
    logic        accept;
    logic [15:0] sp_dec;
    logic        push_ok;
    logic        pop_ok;
    logic [7:0]  push_byte;
    logic [7:0]  pop_byte;
    logic [7:0]  alu_a;
    logic [7:0]  alu_b;
    logic [8:0]  alu_w;
    logic        alu_ac;

    assign accept = cmd_i.valid && state_reg == ST_IDLE;
    assign sp_dec = sp_reg - 16'h0001;
    // stack bytes only land in the internal RAM
    assign push_ok  = sp_dec[15:8] == DATA_FIRST[15:8];
    assign pop_ok   = sp_reg[15:8] == DATA_FIRST[15:8];
    assign pop_byte = ram_reg[sp_reg[7:0]];
    assign alu_a    = cmd_i.data[15:8];
    assign alu_b    = cmd_i.data[7:0];

    // status word first, then return address high, low
    always_comb
    begin
        if (cnt_reg == 2'd2 || op_reg == OP_PUSH_PSW)
            push_byte = psw_reg;
        else if (cnt_reg == 2'd1)
            push_byte = pc_reg[15:8];
        else
            push_byte = pc_reg[7:0];
    end

    always_comb
    begin
        alu_ac = 1'b0;
        alu_w  = 9'h000;
        case (ccs_alu_type'(cmd_i.len[1:0]))
            ALU_ADD:
            begin
                alu_w  = {1'b0, alu_a} + {1'b0, alu_b};
                alu_ac = ({1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]}) > 5'h0F;
            end
            ALU_SUB:
            begin
                alu_w  = {1'b0, alu_a} - {1'b0, alu_b};
                alu_ac = alu_a[3:0] < alu_b[3:0];
            end
            ALU_ROTL: alu_w = {alu_a[7], alu_a[6:0], alu_a[7]};
            ALU_BIT:  alu_w = {alu_a[alu_b[2:0]], alu_a};
            default:  alu_w = 9'h000;
        endcase
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            // reset fetches the reset vector first
            state_reg <= ST_VLO;
            vec_reg   <= VEC_FIRST;
            op_reg    <= OP_NONE;
            cnt_reg   <= 2'd0;
        end
        else
        begin
            case (state_reg)
                ST_VLO:   state_reg <= ST_VHI;
                ST_VHI:   state_reg <= ST_VDONE;
                ST_VDONE: state_reg <= ST_IDLE;
                ST_IDLE:
                if (accept)
                begin
                    op_reg <= cmd_i.op;
                    case (cmd_i.op)
                        OP_INT_ACK:
                        begin
                            vec_reg   <= vector_of(cmd_i.data[3:0]);
                            cnt_reg   <= 2'd2;
                            state_reg <= ST_PUSH;
                        end
                        OP_TCALL:
                        begin
                            vec_reg   <= TABLE_CALL_INSTRUCTION_FIRST
                                       + {10'h000, cmd_i.data[4:0], 1'b0};
                            cnt_reg   <= 2'd1;
                            state_reg <= ST_PUSH;
                        end
                        OP_PUSH_PSW:
                        begin
                            cnt_reg   <= 2'd0;
                            state_reg <= ST_PUSH;
                        end
                        OP_RETURN_FROM_INTERRUPT:
                        begin
                            cnt_reg   <= 2'd0;
                            state_reg <= ST_POP;
                        end
                        OP_POP_PSW:
                        begin
                            cnt_reg   <= 2'd2;
                            state_reg <= ST_POP;
                        end
                        default: state_reg <= ST_IDLE;
                    endcase
                end
                ST_PUSH:
                if (cnt_reg != 2'd0)
                    cnt_reg <= cnt_reg - 2'd1;
                else if (op_reg == OP_PUSH_PSW)
                    state_reg <= ST_IDLE;
                else
                    state_reg <= ST_VLO;
                ST_POP:
                if (cnt_reg == 2'd2)
                    state_reg <= ST_IDLE;
                else
                    cnt_reg <= cnt_reg + 2'd1;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // low byte from even address, high byte from odd
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            prog_rd_o   <= 1'b0;
            prog_addr_o <= 16'h0000;
            vlo_reg     <= 8'h00;
        end
        else
        begin
            prog_rd_o <= 1'b0;
            if (state_reg == ST_VLO)
            begin
                prog_rd_o   <= 1'b1;
                prog_addr_o <= vec_reg;
            end
            else if (state_reg == ST_VHI)
            begin
                prog_rd_o   <= 1'b1;
                prog_addr_o <= vec_reg | 16'h0001;
                vlo_reg     <= prog_rdata_i;
            end
        end
    end

    // ************************************************************
    // Program counter
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            pc_reg <= PC_RESET;
        // vector bytes land in the counter
        else if (state_reg == ST_VDONE)
            pc_reg <= {prog_rdata_i, vlo_reg};
        else if (state_reg == ST_POP && op_reg == OP_RETURN_FROM_INTERRUPT
                 && cnt_reg != 2'd2)
        begin
            if (cnt_reg == 2'd0)
                pc_reg[7:0] <= pop_byte;
            else
                pc_reg[15:8] <= pop_byte;
        end
        else if (accept && cmd_i.op == OP_STEP)
            pc_reg <= pc_reg + {13'h0000, cmd_i.len};
        else if (accept && cmd_i.op == OP_JUMP)
            pc_reg <= cmd_i.data;
        else if (accept && cmd_i.op == OP_JUMP_PAIR)
            pc_reg <= {gr_reg[{cmd_i.pair_sel, 1'b1}],
                       gr_reg[{cmd_i.pair_sel, 1'b0}]};
        else if (wr && ofs == OFS_PC)
            pc_reg <= apb_i.pwdata[15:0];
    end

    // ************************************************************
    // Stack pointer and RAM
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            sp_reg <= SP_RESET;
        // decrement ahead of each stacked byte
        else if (state_reg == ST_PUSH)
            sp_reg <= sp_dec;
        else if (state_reg == ST_POP)
            sp_reg <= sp_reg + 16'h0001;
        // software must load this before any stacking
        else if (wr && ofs == OFS_SP)
            sp_reg <= apb_i.pwdata[15:0];
    end

    // RAM serves both data window and stack
    always_ff @(posedge clk_i)
    begin
        if (state_reg == ST_PUSH && push_ok)
            ram_reg[sp_dec[7:0]] <= push_byte;
        else if (wr && ofs == OFS_RAM_DAT)
            ram_reg[ram_idx_reg] <= apb_i.pwdata[7:0];
    end

    // Sticky; a stack access outside RAM wins over a clear
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            fault_reg <= 1'b0;
        else if ((state_reg == ST_PUSH && !push_ok)
                 || (state_reg == ST_POP && !pop_ok))
            fault_reg <= 1'b1;
        else if (wr && ofs == OFS_STAT && apb_i.pwdata[1])
            fault_reg <= 1'b0;
    end

    // ************************************************************
    // Status word
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            psw_reg <= PSW_RESET;
        else if (state_reg == ST_POP && cnt_reg == 2'd2)
            psw_reg <= pop_byte;
        // Only flag-changing commands take priority over a bus write
        else if (accept && cmd_i.op inside {OP_DI, OP_INT_ACK, OP_EI,
                                            OP_ALU})
        begin
            case (cmd_i.op)
                OP_DI, OP_INT_ACK: psw_reg[PSW_IE_BIT] <= 1'b0;
                OP_EI: psw_reg[PSW_IE_BIT] <= 1'b1;
                OP_ALU:
                begin
                    // carry from add, sub, rotate or bit
                    psw_reg[PSW_CY_BIT] <= alu_w[8];
                    if (cmd_i.len[1:0] == 2'(ALU_ADD)
                        || cmd_i.len[1:0] == 2'(ALU_SUB))
                    begin
                        psw_reg[PSW_Z_BIT]  <= alu_w[7:0] == 8'h00;
                        psw_reg[PSW_AC_BIT] <= alu_ac;
                    end
                end
                default: psw_reg <= psw_reg;
            endcase
        end
        else if (wr && ofs == OFS_PSW)
            psw_reg <= apb_i.pwdata[7:0];
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            alu_reg <= 8'h00;
        else if (accept && cmd_i.op == OP_ALU)
            alu_reg <= alu_w[7:0];
    end

    // maskable needs IE and source unmasked; NMI always
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            take_reg <= 1'b0;
        else
            take_reg <= nmi_i | (mask_ok_i & psw_reg[PSW_IE_BIT]);
    end

    // ************************************************************
    // General registers
    // ************************************************************
    // byte and pair access to one file
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < 8; i++)
                gr_reg[i] <= 8'h00;
        end
        else if (wr && ofs >= OFS_PAIR0 && ofs < OFS_BYTE0)
        begin
            // odd register is the high byte
            gr_reg[{pidx, 1'b1}] <= apb_i.pwdata[15:8];
            gr_reg[{pidx, 1'b0}] <= apb_i.pwdata[7:0];
        end
        else if (wr && ofs >= OFS_BYTE0 && ofs < OFS_RAM_IDX)
            gr_reg[bidx] <= apb_i.pwdata[7:0];
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            ram_idx_reg <= 8'h00;
            probe_reg   <= 16'h0000;
        end
        else
        begin
            if (wr && ofs == OFS_RAM_IDX)
                ram_idx_reg <= apb_i.pwdata[7:0];
            // any 16-bit address may be probed
            if (wr && ofs == OFS_PROBE)
                probe_reg <= apb_i.pwdata[15:0];
        end
    end

    // ************************************************************
    // APB read and handshake
    // ************************************************************
    logic [31:0] rd_next;

    always_comb
    begin
        rd_next = 32'h0000_0000;
        if (ofs >= OFS_PAIR0 && ofs < OFS_BYTE0)
            rd_next = {16'h0000, gr_reg[{pidx, 1'b1}],
                       gr_reg[{pidx, 1'b0}]};
        else if (ofs >= OFS_BYTE0 && ofs < OFS_RAM_IDX)
            rd_next = {24'h00_0000, gr_reg[bidx]};
        else
        begin
            case (ofs)
                OFS_PC:      rd_next = {16'h0000, pc_reg};
                OFS_PSW:     rd_next = {24'h00_0000, psw_reg};
                OFS_SP:      rd_next = {16'h0000, sp_reg};
                OFS_STAT:    rd_next = {27'h000_0000, state_reg,
                                        fault_reg, state_reg != ST_IDLE};
                OFS_RAM_IDX: rd_next = {24'h00_0000, ram_idx_reg};
                OFS_RAM_DAT: rd_next = {24'h00_0000, ram_reg[ram_idx_reg]};
                OFS_PROBE:   rd_next = {13'h0000, region_of(probe_reg),
                                        probe_reg};
                default:     rd_next = 32'h0000_0000;
            endcase
        end
    end

    // One wait state: pready rises on the second access cycle
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            pready_reg <= 1'b0;
            perr_reg   <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end
        else
        begin
            pready_reg <= acc & ~pready_reg;
            perr_reg   <= acc & ~pready_reg & ~mapped;
            if (acc && !pready_reg && !apb_i.pwrite && mapped)
                prdata_reg <= rd_next;
            else if (pready_reg)
                prdata_reg <= 32'h0000_0000;
        end
    end

    assign prdata_o      = prdata_reg;
    assign pready_o      = pready_reg;
    assign pslverr_o     = perr_reg;
    assign busy_o        = state_reg != ST_IDLE;
    assign int_take_o    = take_reg;
    assign pc_o          = pc_reg;
    assign sp_o          = sp_reg;
    assign psw_o         = psw_reg;
    assign alu_result_o  = alu_reg;
    assign stack_fault_o = fault_reg;
endmodule

// ===== core/ccs_pkg.sv
// Constants, types and address map of the cpu control state block
package ccs_pkg;
    // Address map of the 64 KB linear space
    localparam logic [15:0] VEC_FIRST     = 16'h0000;
    localparam logic [15:0] VEC_LAST      = 16'h0015;
    localparam logic [15:0] VEC_WATCHDOG  = 16'h0004;
    localparam logic [15:0] VEC_EXT0      = 16'h0006;
    localparam logic [15:0] VEC_EXT1      = 16'h0008;
    localparam logic [15:0] VEC_EXT2      = 16'h000A;
    localparam logic [15:0] VEC_SER_RX    = 16'h000C;
    localparam logic [15:0] VEC_SER_TX    = 16'h000E;
    localparam logic [15:0] VEC_TMR8      = 16'h0010;
    localparam logic [15:0] VEC_TMR16     = 16'h0012;
    localparam logic [15:0] VEC_CONV      = 16'h0014;
    localparam logic [15:0] TABLE_CALL_INSTRUCTION_FIRST   = 16'h0040;
    localparam logic [15:0] TABLE_CALL_INSTRUCTION_LAST    = 16'h007F;
    localparam logic [15:0] DATA_FIRST    = 16'hFE00;
    localparam logic [15:0] SFR_FIRST     = 16'hFF00;
    // Status word
    localparam logic [7:0]  PSW_RESET     = 8'h02;
    localparam int          PSW_IE_BIT    = 7;
    localparam int          PSW_Z_BIT     = 6;
    localparam int          PSW_AC_BIT    = 4;
    localparam int          PSW_CY_BIT    = 0;
    // APB register offsets, then PC and SP reset values
    localparam logic [11:0] OFS_PC        = 12'h000;
    localparam logic [11:0] OFS_PSW       = 12'h004;
    localparam logic [11:0] OFS_SP        = 12'h008;
    localparam logic [11:0] OFS_STAT      = 12'h00C;
    localparam logic [11:0] OFS_PAIR0     = 12'h010;
    localparam logic [11:0] OFS_BYTE0     = 12'h020;
    localparam logic [11:0] OFS_RAM_IDX   = 12'h040;
    localparam logic [11:0] OFS_RAM_DAT   = 12'h044;
    localparam logic [11:0] OFS_PROBE     = 12'h048;
    localparam logic [15:0] PC_RESET      = 16'h0000;
    localparam logic [15:0] SP_RESET      = 16'h0000;

    typedef enum logic [2:0] {RG_VECTOR, RG_TABLE_CALL_INSTRUCTION, RG_PROGRAM, RG_DATA,
                              RG_SFR} ccs_region_type;
    typedef enum logic [3:0] {OP_NONE, OP_STEP, OP_JUMP, OP_JUMP_PAIR,
                              OP_TCALL, OP_INT_ACK, OP_RETURN_FROM_INTERRUPT, OP_PUSH_PSW,
                              OP_POP_PSW, OP_EI, OP_DI, OP_ALU} ccs_op_type;
    typedef enum logic [1:0] {ALU_ADD, ALU_SUB, ALU_ROTL,
                              ALU_BIT} ccs_alu_type;

    typedef struct packed {
        logic        valid;
        ccs_op_type  op;
        logic [15:0] data;
        logic [2:0]  len;
        logic [1:0]  pair_sel;
    } ccs_cmd_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } ccs_apb_req_type;
endpackage

// ===== tb/ccs_core_tb.sv
// Self-checking bench of the control state block
module ccs_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ccs_pkg::*;
    logic clk_i = 1'b0, rst_n_i = 1'b0, mask_ok_i = 1'b0, nmi_i = 1'b0;
    ccs_apb_req_type apb = '0;
    ccs_cmd_type     cmd = '0;
    logic [31:0] prdata, rdv;
    logic pready, pslverr, busy, take, prd, fault, erv;
    logic [15:0] paddr, pc, sp;
    logic [7:0]  program_status_word, alu, mem;
    int failures = 0, compares = 0, cyc = 0;
    ccs_core u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .apb_i(apb),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .cmd_i(cmd), .mask_ok_i(mask_ok_i), .nmi_i(nmi_i),
        .prog_rdata_i(mem), .busy_o(busy), .int_take_o(take),
        .prog_rd_o(prd), .prog_addr_o(paddr), .pc_o(pc), .sp_o(sp),
        .psw_o(program_status_word), .alu_result_o(alu), .stack_fault_o(fault));
    ccs_mem_model u_mem (.clk_i(clk_i), .rd_i(prd), .addr_i(paddr),
        .data_o(mem));
    // ****
    // Shared tasks
    // ****
    initial forever #4 clk_i = ~clk_i;
    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        compares++;
        if (s !== e)
        begin
            failures++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic acc(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge clk_i);
        apb <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk_i);
        apb.penable <= 1'b1;
        do @(posedge clk_i); while (pready !== 1'b1);
        rdv = prdata;
        erv = pslverr;
        apb <= '0;
    endtask
    task automatic op(ccs_op_type o, logic [15:0] d, logic [2:0] l);
        do @(posedge clk_i); while (busy !== 1'b0);
        cmd <= '{1'b1, o, d, l, 2'b00};
        @(posedge clk_i);
        cmd <= '0;
        do @(posedge clk_i); while (busy !== 1'b0);
    endtask
    task automatic print_verdict;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_map;
        logic [18:0] pv [10] = '{19'h0_0000, 19'h0_0015, 19'h2_0016,
            19'h1_0040, 19'h1_007F, 19'h2_0080, 19'h3_FE00, 19'h3_FEFF,
            19'h4_FF00, 19'h4_FFFF};
        chk("pc", 32'h0000_5B5A, pc);
        acc(1'b0, OFS_PSW, 32'h0);
        chk("psw", 32'h0000_0002, rdv);
        for (int i = 0; i < 10; i++)
        begin
            acc(1'b1, OFS_PROBE, 32'(pv[i][15:0]));
            acc(1'b0, OFS_PROBE, 32'h0);
            chk("region", 32'(pv[i]), rdv);
        end
        acc(1'b0, 12'h04C, 32'h0);
        chk("unmapped", 32'h0000_0001, erv);
        $display("map done");
    endtask
    task automatic t_alu;
        logic [15:0] ad [5] = '{16'h0F01, 16'hFF01, 16'h1001, 16'h8000,
            16'h0401};
        logic [7:0] ef [5] = '{8'h10, 8'h51, 8'h10, 8'h01, 8'h00};
        logic [7:0] er [4] = '{8'h10, 8'h00, 8'h0F, 8'h01};
        op(OP_EI, 16'h0000, 3'h0);
        mask_ok_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk("take", 32'h0000_0001, take);
        for (int i = 0; i < 5; i++)
        begin
            op(OP_ALU, ad[i], 3'(i < 2 ? 0 : i - 1));
            chk("flags", ef[i], program_status_word & (i < 3 ? 8'h51 : 8'h01));
            if (i < 4)
                chk("result", er[i], alu);
        end
        op(OP_DI, 16'h0000, 3'h0);
        repeat (2) @(posedge clk_i);
        chk("masked", 32'h0000_0000, take);
        nmi_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk("nmi", 32'h0000_0001, take);
        nmi_i <= 1'b0;
        mask_ok_i <= 1'b0;
        $display("alu done");
    endtask
    task automatic t_stack;
        acc(1'b1, OFS_SP, 32'h0000_FF00);
        acc(1'b1, OFS_PC, 32'h0000_1234);
        op(OP_INT_ACK, 16'h0004, 3'h0);
        chk("ack pc", 32'h0000_5756, pc);
        chk("ack sp", 32'h0000_FEFD, sp);
        op(OP_RETURN_FROM_INTERRUPT, 16'h0000, 3'h0);
        chk("return_from_interrupt pc", 32'h0000_1234, pc);
        chk("return_from_interrupt sp", 32'h0000_FF00, sp);
        op(OP_TCALL, 16'h0003, 3'h0);
        chk("call pc", 32'h0000_1D1C, pc);
        op(OP_PUSH_PSW, 16'h0000, 3'h0);
        chk("push sp", 32'h0000_FEFD, sp);
        op(OP_POP_PSW, 16'h0000, 3'h0);
        chk("pop sp", 32'h0000_FEFE, sp);
        op(OP_STEP, 16'h0000, 3'h3);
        chk("step", 32'h0000_1D1F, pc);
        chk("no fault", 32'h0000_0000, fault);
        acc(1'b1, OFS_SP, 32'h0000_0000);
        op(OP_PUSH_PSW, 16'h0000, 3'h0);
        chk("fault", 32'h0000_0001, fault);
        $display("stack done");
    endtask
    task automatic t_pair;
        acc(1'b1, OFS_BYTE0, 32'h0000_0034);
        acc(1'b1, OFS_BYTE0 + 12'h004, 32'h0000_0012);
        acc(1'b0, OFS_PAIR0, 32'h0);
        chk("pair", 32'h0000_1234, rdv);
        op(OP_JUMP_PAIR, 16'h0000, 3'h0);
        chk("pair pc", 32'h0000_1234, pc);
        op(OP_JUMP, 16'hABCD, 3'h0);
        chk("jump pc", 32'h0000_ABCD, pc);
        $display("pair done");
    endtask
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            print_verdict();
        end
    end
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        do @(posedge clk_i); while (busy !== 1'b0);
        t_map();
        t_alu();
        t_stack();
        t_pair();
        print_verdict();
    end
endmodule

// ===== tb/ccs_mem_model.sv
// Program memory model answering the core's byte reads
module ccs_mem_model
(
    input  wire logic        clk_i,
    input  wire logic        rd_i,
    input  wire logic [15:0] addr_i,
    output logic      [7:0]  data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // vectors and table
    // The core captures the byte at the edge after its strobe, so the
    // answer follows the registered address without a further stage
    // Released bus shows the inverse, never the byte just read
    assign data_o = rd_i ? (addr_i[7:0] ^ 8'h5A) : ~(addr_i[7:0] ^ 8'h5A);
endmodule

// ===== tb/ccs_props.sv
// Checker of the control state block ports
module ccs_props
    import ccs_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire ccs_cmd_type cmd_i,
    input wire logic        mask_ok_i,
    input wire logic        nmi_i,
    input wire logic        busy_o,
    input wire logic        int_take_o,
    input wire logic        prog_rd_o,
    input wire logic [15:0] prog_addr_o,
    input wire logic [15:0] pc_o,
    input wire logic [7:0]  psw_o,
    input wire logic [7:0]  alu_result_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Properties
    // ****
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire take = cmd_i.valid && !busy_o;
    wire ie = psw_o[PSW_IE_BIT];
    a_psw_reset:
        assert property ($rose(rst_n_i) |-> psw_o == PSW_RESET)
        else $error("status word wrong after reset");
    a_vec_fetch:
        assert property ($rose(rst_n_i)
            |=> prog_rd_o && prog_addr_o == 16'h0000
            ##1 prog_rd_o && prog_addr_o == 16'h0001)
        else $error("reset vector fetch wrong");
    a_int_gate:
        assert property (int_take_o == $past(nmi_i | (mask_ok_i & ie)))
        else $error("request gating wrong");
    a_ei_sets:
        assert property (take && cmd_i.op == OP_EI |=> ie)
        else $error("enable flag not set");
    a_ack_clears:
        assert property (take && cmd_i.op inside {OP_DI, OP_INT_ACK} |=> !ie)
        else $error("enable flag not cleared");
    a_zero_flag:
        assert property (take && cmd_i.op == OP_ALU && !cmd_i.len[1]
            |=> psw_o[PSW_Z_BIT] == (alu_result_o == 8'h00))
        else $error("zero flag wrong");
    a_pc_step:
        assert property (take && cmd_i.op == OP_STEP
            |=> pc_o == $past(pc_o) + 16'($past(cmd_i.len)))
        else $error("step advance wrong");
    a_pc_jump:
        assert property (take && cmd_i.op == OP_JUMP
            |=> pc_o == $past(cmd_i.data))
        else $error("jump target wrong");
    c_ack: cover property (take && cmd_i.op == OP_INT_ACK);
    c_alu: cover property (take && cmd_i.op == OP_ALU);
    c_err: cover property (pready_o && pslverr_o);
endmodule
bind ccs_core ccs_props u_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .cmd_i(cmd_i), .mask_ok_i(mask_ok_i), .nmi_i(nmi_i), .busy_o(busy_o),
    .int_take_o(int_take_o), .prog_rd_o(prog_rd_o),
    .prog_addr_o(prog_addr_o), .pc_o(pc_o), .psw_o(psw_o),
    .alu_result_o(alu_result_o), .pready_o(pready_o), .pslverr_o(pslverr_o));
